// ===== dram_sched_pkg.sv
// constants shared by the dram request scheduler files
// assumes one controller clock domain and byte-wide registers
package dram_sched_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_QUEUE_PROMO = 8'h66;
  localparam logic [7:0] OFS_DIMM_SEL = 8'h67;
  localparam logic [7:0] OFS_WR_EXPIRE = 8'h68;
  localparam logic [7:0] OFS_BANK_CTRL = 8'h69;
  localparam logic [7:0] OFS_REORDER = 8'h6A;
  localparam logic [7:0] OFS_INIT_CTRL = 8'h6B;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_QUEUE_PROMO = 8'h00;
  localparam logic [7:0] RST_DIMM_SEL = 8'h50;
  localparam logic [7:0] RST_WR_EXPIRE = 8'h3F;
  localparam logic [7:0] RST_BANK_CTRL = 8'h82;
  localparam logic [7:0] RST_REORDER = 8'h40;
  localparam logic [7:0] RST_INIT_CTRL = 8'h10;
  // ==========================================================
  // field positions
  localparam int QSIZE_HI = 7;
  localparam int QSIZE_LO = 6;
  localparam int PROMO_HI = 3;
  localparam int EXPIRE_HI = 5;
  localparam int PAGES_HI = 7;
  localparam int PAGES_LO = 6;
  localparam int SCRAMBLE_BIT = 5;
  localparam int REFRESH_HI_BIT = 2;
  localparam int MULTI_PAGE_BIT = 0;
  localparam int BYPASS_HI = 7;
  localparam int BYPASS_LO = 4;
  localparam int DRAIN_HI = 3;
  localparam int DLL_CAL_BIT = 7;
  // ==========================================================
  // counts and encodings
  localparam logic [2:0] DEPTH_TWO = 3'h2;
  localparam logic [2:0] DEPTH_THREE = 3'h3;
  localparam logic [2:0] DEPTH_FOUR = 3'h4;
  localparam logic [4:0] REFRESH_HI_LEVEL = 5'h08;
  localparam logic [2:0] PROMO_STEP_SHIFT = 3'h2;
  localparam int NUM_SRC = 4;
  localparam int NUM_RANK = 4;
  localparam int NUM_BANK = 8;
  localparam int ROW_W = 16;
  localparam int ADDR_W = 32;
  // fixed and scrambling address bit positions for bank address
  localparam int BA_FIXED_LSB = 13;
  localparam int BA_SCRAMBLE_LSB = 17;
  typedef enum logic [1:0] {
    SVC_READ = 2'b01,
    SVC_WRITE = 2'b10
  } svc_state_t;
endpackage

// ===== promo_timer.sv
// one requester's aging counter for priority promotion
// assumes request level and grant pulse on the controller clock
`timescale 1ns/1ps
`default_nettype none
module promo_timer
  import dram_sched_pkg::*;
(
  input wire logic core_clk, // controller clock
  input wire logic nrst, // sync reset, active low
  input wire logic req_valid, // request pending
  input wire logic granted, // grant pulse
  input wire logic [3:0] promo_set, // promotion setting
  output logic promoted // request is high priority
);
  logic [6:0] wait_ff;
  logic [6:0] limit;

  // limit is setting times four clocks
  assign limit = {1'b0, promo_set, 2'b00};
  // waiting count, restarts on grant or withdrawal
  always_ff @(posedge core_clk)
  begin
    if (!nrst || !req_valid || granted)
      wait_ff <= 7'h00;
    else if (wait_ff != 7'h7F)
      wait_ff <= wait_ff + 7'h01;
  end
  // promote once waited longer than limit; zero disables
  assign promoted = req_valid && (promo_set != 4'h0)
    && (wait_ff > limit);

  a_promo_zero_off: assert property (@(posedge core_clk) disable iff (!nrst)
    (promo_set == 4'h0) |-> !promoted)
    else $error("promotion active with setting zero");
  a_promo_restart: assert property (@(posedge core_clk) disable iff (!nrst)
    granted |=> (wait_ff == 7'h00))
    else $error("wait count not restarted after grant");
endmodule
`default_nettype wire

// ===== page_table.sv
// open page table, one row register per bank for each rank
// assumes one access lookup per cycle on the controller clock
`timescale 1ns/1ps
`default_nettype none
module page_table
  import dram_sched_pkg::*;
#(
  parameter int RANKS = NUM_RANK,
  parameter int BANKS = NUM_BANK
)
(
  input wire logic core_clk, // controller clock
  input wire logic nrst, // sync reset, active low
  input wire logic acc_valid, // access issued
  input wire logic [1:0] acc_rank, // rank of access
  input wire logic [2:0] acc_bank, // bank of access
  input wire logic [ROW_W-1:0] acc_row, // row of access
  input wire logic multi_page, // multiple page mode on
  input wire logic [1:0] page_count, // pages per rank code
  output logic page_hit, // row already open
  output logic precharge // close bank after access
);
  logic [RANKS*BANKS-1:0] open_ff;
  logic [ROW_W-1:0] row_ff [RANKS*BANKS];
  logic [4:0] idx;
  logic bank_used;

  initial
  begin
    if (RANKS != 4 || BANKS != 8)
      $error("page table supports four ranks of eight banks");
  end
  assign idx = {acc_rank, acc_bank};
  // banks beyond the chosen count run as non-page cycles
  always_comb
  begin
    case (page_count)
      2'b01: bank_used = (acc_bank[2:1] == 2'b00);
      2'b10: bank_used = (acc_bank[2] == 1'b0);
      2'b11: bank_used = 1'b1;
      default: bank_used = 1'b0;
    endcase
  end
  // precharge after every access unless page mode keeps it open
  assign precharge = !(multi_page && bank_used);
  assign page_hit = !precharge && open_ff[idx]
    && (row_ff[idx] == acc_row);
  // track open rows, up to 32 pages across all ranks
  always_ff @(posedge core_clk)
  begin
    if (!nrst || !multi_page)
      open_ff <= '0;
    else if (acc_valid)
      open_ff[idx] <= !precharge;
  end
  always_ff @(posedge core_clk)
  begin
    if (acc_valid && !precharge)
      row_ff[idx] <= acc_row;
  end

  a_unused_closed: assert property (@(posedge core_clk) disable iff (!nrst)
    (acc_valid && !bank_used) |=> !open_ff[$past(idx)])
    else $error("unused bank left open");
endmodule
`default_nettype wire

// ===== dram_request_scheduler.sv
// dram request scheduler: arbitration, read/write service, pages
// assumes byte register port and all inputs on the controller clock
//
// What this block does
// - queue size code sets command queue depth
// - aged normal requests become high priority
// - no low grant while high pending
// - serve reads first, writes when none
// - write service expires after programmed clocks
// - snoop hit flushes hit writes first
// - expiration timer holds during snoop flush
// - drain writes down to threshold, then reads
// - limit bypasses of one queued read
// - page count picks used page registers
// - two, four or eight pages per rank, unused banks closed
// - scrambled bank address from address XOR
// - refresh high after eight or always
// - no multi-page means precharge every access
// - write one starts strobe DLL calibration
`timescale 1ns/1ps
`default_nettype none
module dram_request_scheduler
  import dram_sched_pkg::*;
(
  input wire logic core_clk, // controller clock
  input wire logic nrst, // sync reset, active low
  input wire logic reg_wr, // register write strobe
  input wire logic [7:0] reg_addr, // register offset
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata_ff, // read data
  input wire logic [NUM_SRC-1:0] req_valid, // host,gfx,disp,video
  input wire logic [NUM_SRC-1:0] req_high, // native high priority
  input wire logic refresh_req, // refresh request pulse
  output logic [NUM_SRC-1:0] grant_ff, // source grant pulse
  output logic refresh_grant_ff, // refresh grant pulse
  input wire logic rd_pending, // reads in read queue
  input wire logic [4:0] wr_count, // writes in write queue
  input wire logic wr_done, // one write served
  input wire logic snoop_flush, // snoop-hit writes pending
  output logic serve_writes_ff, // serving write queue
  input wire logic rd_bypassed, // oldest read passed over
  input wire logic rd_head_done, // oldest read served
  output logic bypass_block_ff, // no further bypass
  output logic [2:0] cmdq_depth_ff, // command queue entries
  input wire logic acc_valid, // dram access issued
  input wire logic [1:0] acc_rank, // access rank
  input wire logic [ADDR_W-1:0] acc_addr, // requester address
  input wire logic [ROW_W-1:0] acc_row, // access row
  output logic page_hit_ff, // access hits open row
  output logic precharge_ff, // close page after access
  output logic [2:0] bank_addr_ff, // bank_addr_bit2..0
  output logic dll_cal_ff // strobe DLL calibrating
);
  logic [7:0] queue_promo_ff;
  logic [7:0] dimm_sel_ff;
  logic [7:0] wr_expire_ff;
  logic [7:0] bank_ctrl_ff;
  logic [7:0] reorder_ff;
  logic [7:0] init_ctrl_ff;
  logic [NUM_SRC-1:0] promoted;
  logic [NUM_SRC-1:0] hi_req;
  logic [NUM_SRC-1:0] lo_req;
  logic [NUM_SRC-1:0] nxt_grant;
  logic nxt_refresh_grant;
  logic [4:0] refresh_cnt_ff;
  logic refresh_hi;
  svc_state_t svc_ff;
  svc_state_t nxt_svc;
  logic [5:0] expire_cnt_ff;
  logic expired;
  logic drained;
  logic [3:0] bypass_cnt_ff;
  logic page_hit;
  logic precharge;
  logic [2:0] fixed_ba;
  logic [2:0] scram_ba;

  // ==========================================================
  // register file
  // writes take effect on the next scheduling decision
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      queue_promo_ff <= RST_QUEUE_PROMO;
      dimm_sel_ff <= RST_DIMM_SEL;
      wr_expire_ff <= RST_WR_EXPIRE;
      bank_ctrl_ff <= RST_BANK_CTRL;
      reorder_ff <= RST_REORDER;
      init_ctrl_ff <= RST_INIT_CTRL;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        OFS_QUEUE_PROMO: queue_promo_ff <= reg_wdata;
        OFS_DIMM_SEL: dimm_sel_ff <= reg_wdata;
        OFS_WR_EXPIRE: wr_expire_ff <= reg_wdata;
        OFS_BANK_CTRL: bank_ctrl_ff <= reg_wdata;
        OFS_REORDER: reorder_ff <= reg_wdata;
        OFS_INIT_CTRL: init_ctrl_ff <= reg_wdata;
        default: ;
      endcase
    end
  end
  // read back; unmapped offsets read zero
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      reg_rdata_ff <= 8'h00;
    else
    begin
      case (reg_addr)
        OFS_QUEUE_PROMO: reg_rdata_ff <= queue_promo_ff;
        OFS_DIMM_SEL: reg_rdata_ff <= dimm_sel_ff;
        OFS_WR_EXPIRE: reg_rdata_ff <= wr_expire_ff;
        OFS_BANK_CTRL: reg_rdata_ff <= bank_ctrl_ff;
        OFS_REORDER: reg_rdata_ff <= reorder_ff;
        OFS_INIT_CTRL: reg_rdata_ff <= init_ctrl_ff;
        default: reg_rdata_ff <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // command queue depth from size code
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      cmdq_depth_ff <= DEPTH_TWO;
    else
    begin
      case (queue_promo_ff[QSIZE_HI:QSIZE_LO])
        2'b10: cmdq_depth_ff <= DEPTH_FOUR;
        2'b11: cmdq_depth_ff <= DEPTH_THREE;
        default: cmdq_depth_ff <= DEPTH_TWO;
      endcase
    end
  end

  // ==========================================================
  // promotion timers, one per requesting source
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++)
    begin : g_promo
      promo_timer u_promo (
        .core_clk(core_clk),
        .nrst(nrst),
        .req_valid(req_valid[g]),
        .granted(grant_ff[g]),
        .promo_set(queue_promo_ff[PROMO_HI:0]),
        .promoted(promoted[g])
      );
    end
  endgenerate

  // pending refresh count, high at eight or when forced
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      refresh_cnt_ff <= 5'h00;
    else if (refresh_req && !refresh_grant_ff)
    begin
      if (refresh_cnt_ff != 5'h1F)
        refresh_cnt_ff <= refresh_cnt_ff + 5'h01;
    end
    else if (!refresh_req && refresh_grant_ff)
      refresh_cnt_ff <= refresh_cnt_ff - 5'h01;
  end
  assign refresh_hi = (refresh_cnt_ff != 5'h00)
    && (bank_ctrl_ff[REFRESH_HI_BIT]
    || refresh_cnt_ff >= REFRESH_HI_LEVEL);

  // ==========================================================
  // arbiter: high before low, lowest index first
  assign hi_req = req_valid & ~grant_ff & (req_high | promoted);
  assign lo_req = req_valid & ~grant_ff & ~(req_high | promoted);
  always_comb
  begin
    nxt_grant = '0;
    nxt_refresh_grant = 1'b0;
    if (refresh_hi && !refresh_grant_ff)
      nxt_refresh_grant = 1'b1;
    else if (hi_req != '0)
      nxt_grant = hi_req & (~hi_req + NUM_SRC'(1));
    else if (refresh_cnt_ff != 5'h00 && !refresh_grant_ff)
      nxt_refresh_grant = 1'b1;
    else
      nxt_grant = lo_req & (~lo_req + NUM_SRC'(1));
  end
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      grant_ff <= '0;
      refresh_grant_ff <= 1'b0;
    end
    else
    begin
      grant_ff <= nxt_grant;
      refresh_grant_ff <= nxt_refresh_grant;
    end
  end

  // ==========================================================
  // read/write service policy
  assign drained = ({1'b0, wr_count} <= {2'b00, reorder_ff[DRAIN_HI:0]});
  assign expired = (expire_cnt_ff > wr_expire_ff[EXPIRE_HI:0])
    || (wr_done && expire_cnt_ff >= wr_expire_ff[EXPIRE_HI:0]);
  always_comb
  begin
    nxt_svc = svc_ff;
    case (svc_ff)
      SVC_READ:
      begin
        if (snoop_flush || (!rd_pending && wr_count != 5'h00))
          nxt_svc = SVC_WRITE;
      end
      SVC_WRITE:
      begin
        if (snoop_flush)
          nxt_svc = SVC_WRITE;
        else if (wr_count == 5'h00 || drained)
          nxt_svc = SVC_READ;
        else if (expired && rd_pending)
          nxt_svc = SVC_READ;
      end
      default: nxt_svc = SVC_READ;
    endcase
  end
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      svc_ff <= SVC_READ;
    else
      svc_ff <= nxt_svc;
  end
  // expiration count runs in write service, holds during flush
  always_ff @(posedge core_clk)
  begin
    if (!nrst || svc_ff != SVC_WRITE)
      expire_cnt_ff <= 6'h00;
    else if (!snoop_flush && expire_cnt_ff != 6'h3F)
      expire_cnt_ff <= expire_cnt_ff + 6'h01;
  end
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      serve_writes_ff <= 1'b0;
    else
      serve_writes_ff <= (nxt_svc == SVC_WRITE);
  end

  // ==========================================================
  // bypass limit for the oldest queued read
  always_ff @(posedge core_clk)
  begin
    if (!nrst || rd_head_done)
      bypass_cnt_ff <= 4'h0;
    else if (rd_bypassed && !bypass_block_ff)
      bypass_cnt_ff <= bypass_cnt_ff + 4'h1;
  end
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      bypass_block_ff <= 1'b1;
    else
      bypass_block_ff <= !rd_head_done
        && (bypass_cnt_ff + {3'h0, rd_bypassed && !bypass_block_ff}
        >= reorder_ff[BYPASS_HI:BYPASS_LO]);
  end

  // ==========================================================
  // page management and bank address
  page_table u_pages (
    .core_clk(core_clk),
    .nrst(nrst),
    .acc_valid(acc_valid),
    .acc_rank(acc_rank),
    .acc_bank(bank_addr_ff),
    .acc_row(acc_row),
    .multi_page(bank_ctrl_ff[MULTI_PAGE_BIT]),
    .page_count(bank_ctrl_ff[PAGES_HI:PAGES_LO]),
    .page_hit(page_hit),
    .precharge(precharge)
  );
  assign fixed_ba = acc_addr[BA_FIXED_LSB +: 3];
  assign scram_ba = fixed_ba ^ acc_addr[BA_SCRAMBLE_LSB +: 3];
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      bank_addr_ff <= 3'h0;
      page_hit_ff <= 1'b0;
      precharge_ff <= 1'b1;
    end
    else
    begin
      bank_addr_ff <= bank_ctrl_ff[SCRAMBLE_BIT] ? scram_ba : fixed_ba;
      page_hit_ff <= acc_valid && page_hit;
      precharge_ff <= precharge;
    end
  end

  // strobe DLL calibration follows its control bit
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      dll_cal_ff <= 1'b0;
    else
      dll_cal_ff <= init_ctrl_ff[DLL_CAL_BIT];
  end

  // ==========================================================
  a_high_first: assert property (@(posedge core_clk) disable iff (!nrst)
    (hi_req != '0) |=> ((grant_ff & $past(lo_req)) == '0))
    else $error("low request granted while high pending");
  a_read_first: assert property (@(posedge core_clk) disable iff (!nrst)
    (svc_ff == SVC_READ && rd_pending && !snoop_flush)
    |=> !serve_writes_ff)
    else $error("writes served with reads pending");
  a_flush_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    (svc_ff == SVC_WRITE && snoop_flush)
    |=> $stable(expire_cnt_ff) && svc_ff == SVC_WRITE)
    else $error("expiration count moved during flush");
  a_drain_stop: assert property (@(posedge core_clk) disable iff (!nrst)
    (svc_ff == SVC_WRITE && !snoop_flush && drained)
    |=> svc_ff == SVC_READ)
    else $error("write service kept past threshold");
  a_no_multi: assert property (@(posedge core_clk) disable iff (!nrst)
    !bank_ctrl_ff[MULTI_PAGE_BIT] |=> precharge_ff)
    else $error("page held open in non-page mode");
  a_qdepth: assert property (@(posedge core_clk) disable iff (!nrst)
    (queue_promo_ff[QSIZE_HI:QSIZE_LO] == 2'b11)
    |=> cmdq_depth_ff == DEPTH_THREE)
    else $error("queue depth code misread");
  a_refresh_force: assert property (@(posedge core_clk) disable iff (!nrst)
    (refresh_cnt_ff >= REFRESH_HI_LEVEL && !refresh_grant_ff)
    |=> refresh_grant_ff)
    else $error("accumulated refresh not granted");
endmodule
`default_nettype wire

// ===== write_drain_model.sv
// far-side model: the memory bus draining one queued write per clock
// assumes the scheduler's serve level and a bench strobe that loads depth
`timescale 1ns/1ps
`default_nettype none
module write_drain_model
(
  input wire logic core_clk, // controller clock
  input wire logic nrst, // sync reset, active low
  input wire logic serve, // scheduler serving writes
  input wire logic load, // bench loads queue depth
  input wire logic [4:0] load_val, // new queue depth
  output logic [4:0] wr_count, // writes still queued
  output logic wr_done // one write finished
);
  // ==========================================================
  // drain
  // a write completes every clock while served and queue not empty
  assign wr_done = serve && (wr_count != 5'h00);
  // queue depth, loaded by the bench or drained
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      wr_count <= 5'h00;
    else if (load)
      wr_count <= load_val;
    else if (wr_done)
      wr_count <= wr_count - 5'h01;
  end
endmodule
`default_nettype wire

// ===== dram_request_scheduler_tb.sv
// self-checking bench for the dram request scheduler
// assumes the write drain model stands behind the write queue
`timescale 1ns/1ps
`default_nettype none
module dram_request_scheduler_tb;
  import dram_sched_pkg::*;
  // ==========================================================
  // signals
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata_ff;
  logic [3:0] req_valid = 4'h0;
  logic [3:0] req_high = 4'h0;
  logic refresh_req = 1'b0;
  logic [3:0] grant_ff;
  logic refresh_grant_ff;
  logic rd_pending = 1'b1;
  logic [4:0] wr_count;
  logic wr_done;
  logic snoop_flush = 1'b0;
  logic serve_writes_ff;
  logic rd_bypassed = 1'b0;
  logic rd_head_done = 1'b0;
  logic bypass_block_ff;
  logic [2:0] cmdq_depth_ff;
  logic acc_valid = 1'b0;
  logic [31:0] acc_addr = 32'h00000000;
  logic page_hit_ff;
  logic precharge_ff;
  logic [2:0] bank_addr_ff;
  logic dll_cal_ff;
  logic q_load = 1'b0;
  logic [4:0] q_val = 5'h00;
  logic [7:0] rst_tab [6] = '{8'h00, 8'h50, 8'h3F, 8'h82, 8'h40, 8'h10};
  logic [7:0] dep_tab [4] = '{8'h02, 8'h02, 8'h04, 8'h03};
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int g0_cnt = 0;
  int rf_cnt = 0;
  int snap = 0;
  // ==========================================================
  // design and far side
  dram_request_scheduler DUT (
    .core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_ff(reg_rdata_ff), .req_valid(req_valid),
    .req_high(req_high), .refresh_req(refresh_req),
    .grant_ff(grant_ff), .refresh_grant_ff(refresh_grant_ff),
    .rd_pending(rd_pending), .wr_count(wr_count), .wr_done(wr_done),
    .snoop_flush(snoop_flush), .serve_writes_ff(serve_writes_ff),
    .rd_bypassed(rd_bypassed), .rd_head_done(rd_head_done),
    .bypass_block_ff(bypass_block_ff), .cmdq_depth_ff(cmdq_depth_ff),
    .acc_valid(acc_valid), .acc_rank(2'h0), .acc_addr(acc_addr),
    .acc_row(16'h0123), .page_hit_ff(page_hit_ff),
    .precharge_ff(precharge_ff), .bank_addr_ff(bank_addr_ff),
    .dll_cal_ff(dll_cal_ff));
  write_drain_model q (
    .core_clk(core_clk), .nrst(nrst), .serve(serve_writes_ff),
    .load(q_load), .load_val(q_val), .wr_count(wr_count),
    .wr_done(wr_done));
  // ==========================================================
  // clock, grant counters and hang limit
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (grant_ff[0] === 1'b1)
      g0_cnt <= g0_cnt + 1;
    if (refresh_grant_ff === 1'b1)
      rf_cnt <= rf_cnt + 1;
    if (cycles == 5000)
    begin
      err_count++;
      test_done();
    end
  end
  // ==========================================================
  // tasks
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    tick(1);
    check(reg_rdata_ff, exp);
  endtask
  task automatic wait_sw(input logic v, input int n);
    for (int i = 0; i < n && serve_writes_ff !== v; i++)
      tick(1);
    check(8'(serve_writes_ff), 8'(v));
  endtask
  task automatic qload(input logic [4:0] v);
    q_val = v;
    q_load = 1'b1;
    tick(1);
    q_load = 1'b0;
  endtask
  task automatic byp(input logic head);
    rd_head_done = head;
    rd_bypassed = !head;
    tick(1);
    rd_head_done = 1'b0;
    rd_bypassed = 1'b0;
    tick(1);
  endtask
  task automatic acc(input logic [31:0] a);
    acc_addr = a;
    acc_valid = 1'b1;
    tick(4);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    tick(8);
    nrst = 1'b1;
    // register reset values, unmapped place, readback
    foreach (rst_tab[i])
      rd(OFS_QUEUE_PROMO + 8'(i), rst_tab[i]);
    wr(8'h70, 8'hA5);
    rd(8'h70, 8'h00);
    wr(OFS_DIMM_SEL, 8'h50);
    rd(OFS_DIMM_SEL, 8'h50);
    // queue depth per size code
    foreach (dep_tab[i])
    begin
      wr(OFS_QUEUE_PROMO, 8'(i << 6));
      tick(1);
      check(8'(cmdq_depth_ff), dep_tab[i]);
    end
    // reads first, drain to threshold of two
    wr(OFS_REORDER, 8'h42);
    qload(5'h0A);
    tick(4);
    check(8'(serve_writes_ff), 8'h00);
    rd_pending = 1'b0;
    wait_sw(1'b1, 5);
    rd_pending = 1'b1;
    wait_sw(1'b0, 20);
    check(8'(wr_count inside {5'h01, 5'h02}), 8'h01);
    // expiration after three clocks of write service
    wr(OFS_REORDER, 8'h40);
    wr(OFS_WR_EXPIRE, 8'h03);
    qload(5'h10);
    rd_pending = 1'b0;
    wait_sw(1'b1, 5);
    rd_pending = 1'b1;
    wait_sw(1'b0, 10);
    check(8'(wr_count > 5'h05), 8'h01);
    // snoop flush forces writes and freezes expiry
    qload(5'h10);
    snoop_flush = 1'b1;
    wait_sw(1'b1, 5);
    tick(12);
    check(8'(serve_writes_ff), 8'h01);
    snoop_flush = 1'b0;
    wait_sw(1'b0, 10);
    check(8'(wr_count), 8'h00);
    // high before low, promotion off then on
    wr(OFS_QUEUE_PROMO, 8'h00);
    req_high = 4'h6;
    req_valid = 4'h7;
    for (int i = 0; i < 5 && grant_ff === 4'h0; i++)
      tick(1);
    check(8'(grant_ff), 8'h02);
    snap = g0_cnt;
    tick(40);
    check(8'(g0_cnt - snap), 8'h00);
    wr(OFS_QUEUE_PROMO, 8'h01);
    snap = g0_cnt;
    tick(30);
    check(8'(g0_cnt > snap), 8'h01);
    check(8'(g0_cnt - snap <= 7), 8'h01);
    // refresh priority after eight, then always
    wr(OFS_QUEUE_PROMO, 8'h00);
    snap = rf_cnt;
    refresh_req = 1'b1;
    tick(7);
    refresh_req = 1'b0;
    tick(10);
    check(8'(rf_cnt - snap), 8'h00);
    refresh_req = 1'b1;
    tick(1);
    refresh_req = 1'b0;
    tick(10);
    check(8'(rf_cnt - snap), 8'h01);
    wr(OFS_BANK_CTRL, 8'h86);
    tick(20);
    check(8'(rf_cnt - snap), 8'h08);
    req_valid = 4'h0;
    // bypass limit of two, then zero
    wr(OFS_REORDER, 8'h20);
    byp(1'b1);
    check(8'(bypass_block_ff), 8'h00);
    byp(1'b0);
    check(8'(bypass_block_ff), 8'h00);
    byp(1'b0);
    check(8'(bypass_block_ff), 8'h01);
    wr(OFS_REORDER, 8'h00);
    byp(1'b1);
    check(8'(bypass_block_ff), 8'h01);
    // page modes, page count kept within banks, page count code zero
    wr(OFS_BANK_CTRL, 8'h80);
    acc(32'h00000000);
    check(8'(precharge_ff), 8'h01);
    wr(OFS_BANK_CTRL, 8'h81);
    acc(32'h00000000);
    check(8'(precharge_ff), 8'h00);
    check(8'(page_hit_ff), 8'h01);
    acc(32'h00008000);
    check(8'(precharge_ff), 8'h01);
    wr(OFS_BANK_CTRL, 8'h01);
    acc(32'h00000000);
    check(8'(precharge_ff), 8'h01);
    // bank address scrambling on and off
    wr(OFS_BANK_CTRL, 8'hA1);
    acc(32'h0006A000);
    check(8'(bank_addr_ff), 8'h06);
    wr(OFS_BANK_CTRL, 8'h81);
    tick(2);
    check(8'(bank_addr_ff), 8'h05);
    acc_valid = 1'b0;
    // strobe delay calibration start and finish
    wr(OFS_INIT_CTRL, 8'h90);
    tick(1);
    check(8'(dll_cal_ff), 8'h01);
    wr(OFS_INIT_CTRL, 8'h10);
    tick(1);
    check(8'(dll_cal_ff), 8'h00);
    test_done();
  end
endmodule
`default_nettype wire
